// file: hw/srrc_ram.sv
// Retained RAM array of the standby region with registered read data.
// Assumes its select and write enable are already gated by the freeze.
module srrc_ram
  import srrc_pkg::*;
#(
  parameter int WORDS = RAM_WORDS,
  parameter int AW    = ADDR_W,
  parameter int DW    = DATA_W
) (
  // Clock.
  input  wire logic          clk,
  // Access port.
  input  wire logic          sel,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [WORDS];

  // Memory has no reset so that its contents survive every reset.
  always_ff @(posedge clk) begin
    if (sel && wrEn) begin
      mem[addr] <= wdata;
    end
    if (sel && !wrEn) begin
      rdata <= mem[addr];
    end
  end
endmodule // srrc_ram

// file: hw/srrc_top.sv
// Standby RAM retention control: freeze, supply switch and power sequence.
// Assumes supply monitor flags and the reset pin are asynchronous inputs.
// Functional notes
// [RQ1] Outside system holds reset before and while main supply goes off.
// [RQ2] Only the 16 Kbyte retained region stays biased in standby.
// [RQ3] Any reset event clears the standby RAM enable bit.
// [RQ4] Enable bit clear freezes the retained RAM interface immediately.
// [RQ5] Reset switches retained RAM supply to the standby reference.
// [RQ6] Interface stays frozen until software sets the enable bit again.
// [RQ7] On core supply collapse the freeze holds regardless of the bit.
// [RQ8] Enable bit is honoured again only after core supply returns.
// [RQ9] Short core supply drops with bit set cause no switch or freeze.
// [RQ10] Guard stage blocks degraded write strobe during power off.
// [RQ11] Outside hardware holds reset pin low and glitch free at power off.
// [RQ12] Low voltage detector holds reset until core supply passes 1.0 V.
// [RQ13] Outside holds reset low 1 ms after supply is stable.
// [RQ14] Flash initialisation starts when the reset pin is released.
// [RQ15] Internal reset release switches RAM supply back to core supply.
// [RQ16] Outside may hold the standby pin low to select external access.
// [RQ17] Freeze forces select and write inactive and holds address, data.
module srrc_top
  import srrc_pkg::*;
#(
  parameter int SETTLE_CNT = SETTLE_CYCLES,
  parameter int FILTER_CNT = DROP_FILTER_CYCLES
) (
  // Clock and synchronous reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Board pins and supply monitors.
  input  wire logic             external_reset_in_n,
  input  wire logic             standby_supply_pin,
  input  wire logic             coreAboveLvd,
  input  wire logic             coreBelowStandby,
  // Software access to the enable bit of peripheral_config_reg.
  input  wire logic             enableWrite,
  input  wire logic             enableWdata,
  output logic                  standby_ram_enable,
  // Core side RAM request and read data.
  input  srrc_ram_req_type      coreReq,
  output logic     [DATA_W-1:0] coreRdata,
  // Status towards the rest of the chip.
  output logic                  internalReset,
  output logic                  flashInitStart,
  output logic                  external_access_select,
  output srrc_src_type          ramSupplySel,
  output logic                  ramFrozen
);
  // Pin synchronisers; the first stage feeds only the second.
  // They carry no reset, so the pins are still sampled while rst is high.
  logic [3:0] syncA_ff;
  logic [3:0] syncB_ff;
  logic [3:0] nxt_syncA;
  logic [3:0] nxt_syncB;
  logic       rstPinN;
  logic       stbyPin;
  logic       coreOk;
  logic       coreDrop;

  always_comb begin
    nxt_syncA = {coreBelowStandby, coreAboveLvd, standby_supply_pin,
                 external_reset_in_n};
    nxt_syncB = syncA_ff;
  end

  always_ff @(posedge clk) begin
    syncA_ff <= nxt_syncA;
    syncB_ff <= nxt_syncB;
  end

  assign rstPinN  = syncB_ff[0];
  assign stbyPin  = syncB_ff[1];
  assign coreOk   = syncB_ff[2];
  assign coreDrop = syncB_ff[3];

  // Drop filter: brief dips are ignored so normal code keeps running.
  // A dip that outlasts the filter is treated as a real supply collapse.
  logic [7:0] dropCnt_ff;
  logic [7:0] nxt_dropCnt;
  logic       collapse_ff;
  logic       nxt_collapse;
  // The sequencer state is declared here because the filter reads it.
  srrc_state_type state_ff;
  srrc_state_type nxt_state;

  always_comb begin
    nxt_dropCnt  = dropCnt_ff;
    nxt_collapse = collapse_ff;
    if (!coreOk) begin
      nxt_collapse = 1'b1; // [RQ7]
      nxt_dropCnt  = 8'h00;
    end else if (coreDrop) begin
      if (dropCnt_ff == 8'(FILTER_CNT - 1)) begin
        nxt_collapse = 1'b1; // [RQ9]
      end else begin
        nxt_dropCnt = dropCnt_ff + 8'h01;
      end
    end else begin
      nxt_dropCnt = 8'h00;
      if (state_ff == SRRC_ST_LVD_HOLD) begin
        nxt_collapse = 1'b0; // [RQ8]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dropCnt_ff  <= 8'h00;
      collapse_ff <= 1'b1;
    end else begin
      dropCnt_ff  <= nxt_dropCnt;
      collapse_ff <= nxt_collapse;
    end
  end

  // Power sequence state machine with a settle counter.
  logic [31:0]    settle_ff;
  logic [31:0]    nxt_settle;

  // The detector hold and collapse states are not restarted, or the
  // collapse flag could never clear in the detector hold state.
  function automatic logic canRestart(input srrc_state_type st);
    return (st != SRRC_ST_LVD_HOLD) && (st != SRRC_ST_COLLAPSE);
  endfunction

  always_comb begin
    nxt_state  = state_ff;
    nxt_settle = settle_ff;
    case (state_ff)
      SRRC_ST_LVD_HOLD: begin
        nxt_settle = 32'h0;
        if (coreOk && !collapse_ff) begin
          nxt_state = SRRC_ST_EXT_HOLD; // [RQ12]
        end
      end
      SRRC_ST_EXT_HOLD: begin
        if (rstPinN) begin
          nxt_state = SRRC_ST_FLASH_INI; // [RQ14]
        end
      end
      SRRC_ST_FLASH_INI: begin
        nxt_settle = settle_ff + 32'h1;
        if (settle_ff == 32'(SETTLE_CNT - 1)) begin
          nxt_state = SRRC_ST_RUN;
        end
      end
      SRRC_ST_RUN: begin
        nxt_settle = 32'h0;
      end
      SRRC_ST_COLLAPSE: begin
        nxt_settle = 32'h0;
        nxt_state  = SRRC_ST_LVD_HOLD;
      end
      default: begin
        nxt_state = SRRC_ST_LVD_HOLD;
      end
    endcase
    // Collapse or a low reset pin restarts the sequence from any state
    // that is not already on its way back through the detector hold.
    if (canRestart(state_ff)) begin
      if (collapse_ff || !coreOk) begin
        nxt_state = SRRC_ST_COLLAPSE; // [RQ7]
      end else if (!rstPinN) begin
        nxt_state = SRRC_ST_EXT_HOLD;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff  <= SRRC_ST_LVD_HOLD;
      settle_ff <= 32'h0;
    end else begin
      state_ff  <= nxt_state;
      settle_ff <= nxt_settle;
    end
  end

  // Internal reset is active in every state except run.
  assign internalReset  = (state_ff != SRRC_ST_RUN);
  assign flashInitStart = (state_ff == SRRC_ST_EXT_HOLD) && rstPinN;

  // Enable bit, cleared by any reset and unusable while supply is gone.
  // A write in the same cycle as a reset is dropped: the reset wins, so
  // the bit reads clear in the cycle after any reset cycle.
  logic enable_ff;
  logic nxt_enable;

  always_comb begin
    nxt_enable = enable_ff;
    if (internalReset) begin
      nxt_enable = ENABLE_RESET; // [RQ3]
    end else if (enableWrite) begin
      nxt_enable = enableWdata; // [RQ6]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_ff <= ENABLE_RESET; // [RQ3]
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  assign standby_ram_enable = enable_ff;

  // Supply select: standby reference during reset, core supply after.
  srrc_src_type src_ff;
  srrc_src_type nxt_src;

  always_comb begin
    nxt_src = src_ff;
    if (internalReset || collapse_ff) begin
      nxt_src = SRRC_SRC_STANDBY; // [RQ5]
    end else begin
      nxt_src = SRRC_SRC_CORE; // [RQ15]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      src_ff <= SRRC_SRC_STANDBY;
    end else begin
      src_ff <= nxt_src;
    end
  end

  assign ramSupplySel = src_ff;

  // External access strap, caught on the cycle reset is released.
  logic eaStrap_ff;
  logic nxt_eaStrap;

  always_comb begin
    nxt_eaStrap = eaStrap_ff;
    if (flashInitStart) begin
      nxt_eaStrap = !stbyPin; // [RQ16]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      eaStrap_ff <= 1'b0;
    end else begin
      eaStrap_ff <= nxt_eaStrap;
    end
  end

  assign external_access_select = eaStrap_ff;

  // Freeze is combinational from the bit so it acts at once; the guard
  // stage overrides the bit while the core supply is not trusted.
  // The source term keeps the array shut in the cycle after reset ends.
  assign ramFrozen = !enable_ff || collapse_ff || !coreOk
                     || (src_ff != SRRC_SRC_CORE); // [RQ4] [RQ7] [RQ10]

  // Hold registers keep the last address and data seen before freeze.
  // Select and write are never held active, so a thaw cannot replay one.
  srrc_ram_req_type hold_ff;
  srrc_ram_req_type nxt_hold;
  srrc_ram_req_type ramReq;

  always_comb begin
    nxt_hold = hold_ff;
    if (!ramFrozen) begin
      nxt_hold = coreReq;
    end
    nxt_hold.sel  = 1'b0;
    nxt_hold.wrEn = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hold_ff <= '0;
    end else begin
      hold_ff <= nxt_hold;
    end
  end

  // Frozen requests reach the array inactive with held address and data.
  always_comb begin
    ramReq = coreReq;
    if (ramFrozen) begin
      ramReq      = hold_ff; // [RQ17]
      ramReq.sel  = 1'b0; // [RQ17]
      ramReq.wrEn = 1'b0; // [RQ10]
    end
  end

  // Only the retained region is instantiated here.
  srrc_ram #(
    .WORDS (RAM_WORDS),
    .AW    (ADDR_W),
    .DW    (DATA_W)
  ) u_ram (
    .clk   (clk),
    .sel   (ramReq.sel),
    .wrEn  (ramReq.wrEn),
    .addr  (ramReq.addr),
    .wdata (ramReq.wdata),
    .rdata (coreRdata)
  ); // [RQ2]
endmodule // srrc_top

// file: pkg/srrc_pkg.sv
// Package for the standby RAM retention control block.
// Assumes one 250 MHz clock; supply monitor levels arrive as async pins.
package srrc_pkg;
  // Retained region of 16 Kbytes, addressed as 16-bit words.
  localparam int RETAIN_BYTES = 16384;
  localparam int WORD_BYTES   = 2;
  localparam int RAM_WORDS    = RETAIN_BYTES / WORD_BYTES;
  localparam int ADDR_W       = $clog2(RAM_WORDS);
  localparam int DATA_W       = 16;

  // Regulator settle time after reset pin release, counted in the flash init state.
  localparam int SETTLE_TIME_US = 1000;
  localparam int CLK_MHZ        = 250;
  localparam int SETTLE_CYCLES  = SETTLE_TIME_US * CLK_MHZ;

  // Glitch filter length for the coreBelowStandby comparator output.
  localparam int DROP_FILTER_CYCLES = 16;

  // Reset value of the enable bit.
  localparam logic ENABLE_RESET = 1'b0;

  // Supply source selector.
  typedef enum logic [0:0] {
    SRRC_SRC_STANDBY = 1'b0,
    SRRC_SRC_CORE    = 1'b1
  } srrc_src_type;

  // Power sequence states.
  typedef enum logic [2:0] {
    SRRC_ST_LVD_HOLD  = 3'b000,
    SRRC_ST_EXT_HOLD  = 3'b001,
    SRRC_ST_FLASH_INI = 3'b010,
    SRRC_ST_RUN       = 3'b011,
    SRRC_ST_COLLAPSE  = 3'b100
  } srrc_state_type;

  // RAM access request from the core side.
  typedef struct packed {
    logic              sel;
    logic              wrEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srrc_ram_req_type;
endpackage : srrc_pkg

// file: verif/srrc_monitor.sv
// Port assertions for the standby RAM retention control block.
// Assumes one clock domain with a synchronous active high reset.
module srrc_monitor
  import srrc_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         coreAboveLvd,
  input wire logic         enableWrite,
  input wire logic         enableWdata,
  // Design outputs.
  input wire logic         standby_ram_enable,
  input wire logic         internalReset,
  input wire logic         flashInitStart,
  input wire srrc_src_type ramSupplySel,
  input wire logic         ramFrozen
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Reset checks must not be disabled by the reset they watch.
  rst_clear_a: assert property (disable iff (1'b0)
    rst |=> !standby_ram_enable) else $error("enable kept over reset");
  rst_standby_a: assert property (disable iff (1'b0)
    rst |=> ramSupplySel == SRRC_SRC_STANDBY) else $error("supply not ref");
  freeze_off_a: assert property (
    !standby_ram_enable |-> ramFrozen) else $error("open while disabled");
  freeze_src_a: assert property (
    ramSupplySel == SRRC_SRC_STANDBY |-> ramFrozen) else $error("open on ref");
  ireset_clear_a: assert property (
    internalReset |=> !standby_ram_enable) else $error("enable in reset");
  // A software write is honoured only outside reset.
  sequence swSet;
    enableWrite && enableWdata && !internalReset;
  endsequence
  enable_set_a: assert property (
    swSet |=> standby_ram_enable) else $error("enable write lost");
  supply_back_a: assert property (
    $fell(internalReset) |=> ramSupplySel == SRRC_SRC_CORE)
    else $error("supply not switched back");
  flash_pulse_a: assert property (
    flashInitStart |=> !flashInitStart && internalReset)
    else $error("flash start not a pulse");
  lvd_hold_a: assert property (
    !coreAboveLvd |-> ##[0:12] internalReset) else $error("no lvd reset");
endmodule // srrc_monitor

bind srrc_top srrc_monitor mon_u (.clk, .rst, .coreAboveLvd, .enableWrite,
  .enableWdata, .standby_ram_enable, .internalReset, .flashInitStart,
  .ramSupplySel, .ramFrozen);

// file: verif/srrc_supply_model.sv
// Board reset and supply supervisor facing the retention control block.
// Assumes its tasks are called by one bench process.
module srrc_supply_model #(
  parameter int HOLD = 12
) (
  // Clock.
  input wire logic clk,
  // Pins driven towards the device.
  output logic     external_reset_in_n,
  output logic     standby_supply_pin,
  output logic     coreAboveLvd,
  output logic     coreBelowStandby
);
  timeunit 1ns;
  timeprecision 1ps;
  // Power starts off with the reset pin held low.
  initial begin
    external_reset_in_n = 1'b0;
    standby_supply_pin  = 1'b1;
    coreAboveLvd        = 1'b0;
    coreBelowStandby    = 1'b1;
  end
  // Supply first, then a settle time before reset is let go.
  task powerUp(input logic extAccess);
    @(posedge clk) #1;
    coreAboveLvd       = 1'b1;
    coreBelowStandby   = 1'b0;
    standby_supply_pin = !extAccess;
    repeat (HOLD) @(posedge clk);
    #1 external_reset_in_n = 1'b1;
  endtask
  // Reset goes low before the supply is removed.
  task powerDown;
    @(posedge clk) #1 external_reset_in_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 coreAboveLvd = 1'b0;
    coreBelowStandby = 1'b1;
  endtask
  // A short supply dip below the standby reference.
  task dip(input int n);
    @(posedge clk) #1 coreBelowStandby = 1'b1;
    repeat (n) @(posedge clk);
    #1 coreBelowStandby = 1'b0;
  endtask
endmodule // srrc_supply_model

// file: verif/testbench.sv
// Self-checking bench for the standby RAM retention control block.
// Assumes the supply model drives the pins and the checker is bound.
module testbench
  import srrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              enableWrite = 1'b0;
  logic              enableWdata = 1'b0;
  srrc_ram_req_type  coreReq = '0;
  logic              extRstN, stbyPin, coreOk, coreLow, enable, iRst;
  logic              flashGo, extAcc, frozen, rdPend;
  srrc_src_type      supply;
  logic [DATA_W-1:0] rdata, d;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] expQ[$];
  int                bad_count = 0;
  int                samples_checked = 0;

  // Clock at 250 MHz.
  always #2 clk = ~clk;

  srrc_supply_model m_u (.clk(clk), .external_reset_in_n(extRstN),
    .standby_supply_pin(stbyPin), .coreAboveLvd(coreOk),
    .coreBelowStandby(coreLow));
  // Short counts keep the power sequence brief.
  srrc_top #(.SETTLE_CNT(8), .FILTER_CNT(4)) dut_u (.clk(clk), .rst(rst),
    .external_reset_in_n(extRstN), .standby_supply_pin(stbyPin),
    .coreAboveLvd(coreOk), .coreBelowStandby(coreLow),
    .enableWrite(enableWrite), .enableWdata(enableWdata),
    .standby_ram_enable(enable), .coreReq(coreReq), .coreRdata(rdata),
    .internalReset(iRst), .flashInitStart(flashGo),
    .external_access_select(extAcc), .ramSupplySel(supply),
    .ramFrozen(frozen));

  task check(string name, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task finish_test;
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task step;
    @(posedge clk) #1;
  endtask
  task setEn(input logic v);
    enableWrite = 1'b1;
    enableWdata = v;
    step;
    enableWrite = 1'b0;
    step;
  endtask
  task access(input logic wr, input logic [DATA_W-1:0] e);
    if (!wr) expQ.push_back(e);
    coreReq = '{1'b1, wr, a, d};
    step;
    coreReq.sel = 1'b0;
    step;
  endtask
  // Reset release is bounded so a stuck sequence cannot hang.
  task waitRun;
    for (int i = 0; i < 100 && iRst !== 1'b0; i++) step;
    step;
  endtask

  // Read data lands one cycle after the read; the oldest note is compared.
  always @(negedge clk) begin
    if (rdPend === 1'b1) check("rdata", rdata, expQ.pop_front());
    rdPend = coreReq.sel && !coreReq.wrEn;
  end

  // Watchdog: the whole run needs well under a thousand cycles.
  initial begin
    #20000;
    bad_count++;
    finish_test;
  end

  initial begin
    d = $urandom(74833);
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    check("enable", enable, 1'b0);
    check("supply", supply, SRRC_SRC_STANDBY);
    m_u.powerUp(1'b0);
    setEn(1'b1);
    check("enable", enable, 1'b0);
    waitRun;
    check("supply", supply, SRRC_SRC_CORE);
    check("frozen", frozen, 1'b1);
    setEn(1'b1);
    check("frozen", frozen, 1'b0);
    a = $urandom;
    d = $urandom;
    access(1'b1, '0);
    // A write while disabled must leave the stored word alone.
    setEn(1'b0);
    d = ~d;
    access(1'b1, '0);
    setEn(1'b1);
    access(1'b0, ~d);
    m_u.dip(3);
    repeat (6) step;
    check("ireset", iRst, 1'b0);
    check("enable", enable, 1'b1);
    check("frozen", frozen, 1'b0);
    m_u.powerDown;
    repeat (12) step;
    check("enable", enable, 1'b0);
    check("frozen", frozen, 1'b1);
    check("supply", supply, SRRC_SRC_STANDBY);
    m_u.powerUp(1'b1);
    waitRun;
    check("extacc", extAcc, 1'b1);
    setEn(1'b1);
    access(1'b0, ~d);
    step;
    finish_test;
  end
endmodule // testbench
